//--- logic/pcx_pkg.sv
// Constants and types shared by the control-3 and indirect access logic.
// Assumes a 40 MHz management clock and a decoded management register port.
package pcx_pkg;

  // Direct register offsets on the five-bit management address.
  localparam logic [4:0]  OFF_CTL3     = 5'h0b;  // Link control three.
  localparam logic [4:0]  OFF_ACC_CTL  = 5'h0d;  // Indirect access control.
  localparam logic [4:0]  OFF_ADDAT    = 5'h0e;  // Indirect address or data.

  // Reset values of the three registers.
  localparam logic [15:0] CTL3_RST     = 16'h0000;
  localparam logic [15:0] ACC_CTL_RST  = 16'h0000;
  localparam logic [15:0] PTR_RST      = 16'h0000;

  // Writable bits; all other bits ignore writes and read as zero.
  localparam logic [15:0] CTL3_WMASK   = 16'h007f;

  // Field positions.
  localparam int          CTL3_POL_BIT = 6;   // Polarity swap.
  localparam int          CTL3_XOV_BIT = 5;   // Pair crossover.
  localparam int          FLD_RX_BIT   = 3;   // Fast drop on receive errors.
  localparam int          FLD_MLT_BIT  = 2;   // Fast drop on coding violations.
  localparam int          FLD_SNR_BIT  = 1;   // Fast drop on low signal to noise.
  localparam int          FLD_NRG_BIT  = 0;   // Fast drop on energy loss.
  localparam int          FN_HI        = 15;
  localparam int          FN_LO        = 14;
  localparam int          DEV_HI       = 4;
  localparam int          DEV_LO       = 0;

  // The only target device id that the indirect path answers.
  localparam logic [4:0]  DEV_OWN      = 5'h1f;

  // Function field of the access control register.
  typedef enum logic [1:0] {
    PCX_FN_ADDR   = 2'h0,  // Data port reaches the pointer.
    PCX_FN_DATA   = 2'h1,  // Data, pointer kept.
    PCX_FN_INC_RW = 2'h2,  // Data, pointer steps after reads and writes.
    PCX_FN_INC_WR = 2'h3   // Data, pointer steps after writes only.
  } pcx_fn_t;

  // Fast link-drop thresholds per observation window.
  localparam logic [5:0]  THR_RX       = 6'h20;  // 32 receive errors.
  localparam logic [5:0]  THR_MLT      = 6'h14;  // 20 coding violations.
  localparam logic [5:0]  THR_SNR      = 6'h14;  // 20 threshold crossings.

  // Observation window timing.
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          WINDOW_NS     = 10000;
  localparam int          WIN_CYC       = WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [8:0]  WIN_LAST      = 9'(WIN_CYC - 1);
  localparam logic [8:0]  WIN_ZERO      = 9'h000;

endpackage

//--- logic/pcx_win_count.sv
// Threshold counter for one fast link-drop trigger.
// Assumes window_start and evt_in come from logic on the same clock.
`timescale 1ns/100ps

module pcx_win_count #(
  parameter logic [5:0] THRESH = 6'h14
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic window_start,
  input  wire logic evt_in,
  output logic      hit
);

  // All state of the counter.
  typedef struct packed {
    logic [5:0] cnt;  // Events seen in the current window.
    logic       hit;  // One-cycle pulse when the threshold is met.
  } pcx_wc_state_t;

  pcx_wc_state_t s_q;  // Registered state.
  pcx_wc_state_t s_d;  // Next state.
  logic [5:0]    base; // Count that this cycle builds on.

  // Counting restarts at each window start, so an event in the first cycle of
  // a window counts toward the new window, never the old one.
  always_comb
  begin
    s_d  = s_q;
    base = window_start ? 6'h00 : s_q.cnt;
    s_d.hit = 1'b0;
    if (!enable)
    begin
      // A disabled trigger holds no stale count for when it is enabled.
      s_d.cnt = 6'h00;
    end
    else if (evt_in && base != THRESH)
    begin
      s_d.cnt = base + 6'h01;
      s_d.hit = (base + 6'h01) == THRESH;
    end
    else
    begin
      // Saturate at the threshold so that one window fires only once.
      s_d.cnt = base;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hit = s_q.hit;

  // A pulse always stands on a full count.
  property p_hit_count;
    @(posedge clk) disable iff (sys_rst)
      hit |-> (s_q.cnt == THRESH);
  endproperty
  a_hit_count: assert property (p_hit_count) else $error("hit without full count");

endmodule

//--- logic/pcx_ctrl3_indirect.sv
// Control-3 register, fast link-drop logic and indirect extended access.
// Assumes a decoded management register port on clk and extended registers
// that answer a read strobe with data in the same cycle.
`timescale 1ns/100ps

module pcx_ctrl3_indirect (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic             ext_wr,
  output logic             ext_rd,
  output logic [15:0]      ext_addr,
  output logic [15:0]      ext_wdata,
  input  wire logic [15:0] ext_rdata,
  input  wire logic        rx_err_evt,
  input  wire logic        mlt3_viol_evt,
  input  wire logic        low_snr_evt,
  input  wire logic        energy_loss,
  output logic             polarity_swap,
  output logic             pair_crossover,
  output logic             port_mirror,
  output logic             link_drop
);

  // All state of the block.
  typedef struct packed {
    logic [15:0]     ctl3;     // Link control three, writable bits only.
    pcx_pkg::pcx_fn_t fn;      // Function field.
    logic [4:0]      dev;      // Target device id.
    logic [15:0]     ptr;      // Extended set address pointer.
    logic [8:0]      win;      // Position in the observation window.
    logic            rd_pend;  // A read is in its second cycle.
    logic            rd_ext;   // That read comes from the extended set.
    logic [15:0]     rd_hold;  // Direct read value waiting to be answered.
    logic [15:0]     rdata;    // Read answer.
    logic            rvalid;   // Read answer strobe.
    logic            ext_wr;   // Extended write strobe.
    logic            ext_rd;   // Extended read strobe.
    logic [15:0]     ext_addr; // Extended register address.
    logic [15:0]     ext_wdata;// Extended write data.
    logic            pol;      // Polarity swap to the line logic.
    logic            xov;      // Pair crossover to the line logic.
    logic            mirror;   // Port mirror to the line logic.
    logic            drop;     // Link drop request.
  } pcx_state_t;

  pcx_state_t s_q;      // Registered state.
  pcx_state_t s_d;      // Next state.
  logic       win_start;// First cycle of an observation window.
  logic       hit_rx;   // Receive error trigger fired.
  logic       hit_mlt;  // Coding violation trigger fired.
  logic       hit_snr;  // Low signal to noise trigger fired.
  logic       dev_ok;   // Indirect path addresses this device.
  logic       wr_ad;    // Write to the address or data register.
  logic       rd_ad;    // Read of the address or data register.

  assign win_start = (s_q.win == pcx_pkg::WIN_ZERO);
  assign dev_ok    = (s_q.dev == pcx_pkg::DEV_OWN);
  assign wr_ad     = mgmt_wr && (mgmt_addr == pcx_pkg::OFF_ADDAT);
  // A write in the same cycle as a read takes the port; the read is dropped.
  assign rd_ad     = mgmt_rd && !mgmt_wr && (mgmt_addr == pcx_pkg::OFF_ADDAT);

  // Counting triggers share one free-running window so that they stay aligned.
  pcx_win_count #(
    .THRESH       (pcx_pkg::THR_RX)
  ) u_cnt_rx (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .enable       (s_q.ctl3[pcx_pkg::FLD_RX_BIT]),
    .window_start (win_start),
    .evt_in       (rx_err_evt),
    .hit          (hit_rx)
  );

  pcx_win_count #(
    .THRESH       (pcx_pkg::THR_MLT)
  ) u_cnt_mlt (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .enable       (s_q.ctl3[pcx_pkg::FLD_MLT_BIT]),
    .window_start (win_start),
    .evt_in       (mlt3_viol_evt),
    .hit          (hit_mlt)
  );

  pcx_win_count #(
    .THRESH       (pcx_pkg::THR_SNR)
  ) u_cnt_snr (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .enable       (s_q.ctl3[pcx_pkg::FLD_SNR_BIT]),
    .window_start (win_start),
    .evt_in       (low_snr_evt),
    .hit          (hit_snr)
  );

  // Next-state logic for registers, indirect access and link drop.
  always_comb
  begin
    s_d        = s_q;
    s_d.ext_wr = 1'b0;
    s_d.ext_rd = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.rd_pend = 1'b0;
    s_d.rd_ext = 1'b0;

    // Window counter wraps every ten microseconds.
    if (s_q.win == pcx_pkg::WIN_LAST)
    begin
      s_d.win = pcx_pkg::WIN_ZERO;
    end
    else
    begin
      s_d.win = s_q.win + 9'h001;
    end

    // Register writes; reserved bits are masked away.
    if (mgmt_wr)
    begin
      if (mgmt_addr == pcx_pkg::OFF_CTL3)
      begin
        s_d.ctl3 = mgmt_wdata & pcx_pkg::CTL3_WMASK;
      end
      else if (mgmt_addr == pcx_pkg::OFF_ACC_CTL)
      begin
        s_d.fn  = pcx_pkg::pcx_fn_t'(mgmt_wdata[pcx_pkg::FN_HI:pcx_pkg::FN_LO]);
        s_d.dev = mgmt_wdata[pcx_pkg::DEV_HI:pcx_pkg::DEV_LO];
      end
      else if (wr_ad && dev_ok)
      begin
        // Foreign device ids fall through untouched.
        if (s_q.fn == pcx_pkg::PCX_FN_ADDR)
        begin
          s_d.ptr = mgmt_wdata;
        end
        else
        begin
          // The pointed register is written; direct addresses never reach it.
          s_d.ext_wr    = 1'b1;
          s_d.ext_addr  = s_q.ptr;
          s_d.ext_wdata = mgmt_wdata;
          if (s_q.fn != pcx_pkg::PCX_FN_DATA)
          begin
            s_d.ptr = s_q.ptr + 16'h0001;
          end
        end
      end
    end
    else if (mgmt_rd)
    begin
      // Every read answers two cycles later, whatever its source.
      s_d.rd_pend = 1'b1;
      s_d.rd_hold = 16'h0000;
      if (mgmt_addr == pcx_pkg::OFF_CTL3)
      begin
        s_d.rd_hold = s_q.ctl3 & pcx_pkg::CTL3_WMASK;
      end
      else if (mgmt_addr == pcx_pkg::OFF_ACC_CTL)
      begin
        s_d.rd_hold[pcx_pkg::FN_HI:pcx_pkg::FN_LO]   = s_q.fn;
        s_d.rd_hold[pcx_pkg::DEV_HI:pcx_pkg::DEV_LO] = s_q.dev;
      end
      else if (rd_ad && dev_ok)
      begin
        if (s_q.fn == pcx_pkg::PCX_FN_ADDR)
        begin
          s_d.rd_hold = s_q.ptr;
        end
        else
        begin
          s_d.ext_rd   = 1'b1;
          s_d.ext_addr = s_q.ptr;
          s_d.rd_ext   = 1'b1;
          // Only the read-and-write increment mode steps after a read.
          if (s_q.fn == pcx_pkg::PCX_FN_INC_RW)
          begin
            s_d.ptr = s_q.ptr + 16'h0001;
          end
        end
      end
    end

    // Second read cycle: the extended set answers during its strobe.
    if (s_q.rd_pend)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = s_q.rd_ext ? ext_rdata : s_q.rd_hold;
    end

    // Line controls follow the stored bits one cycle later.
    s_d.pol    = s_q.ctl3[pcx_pkg::CTL3_POL_BIT];
    s_d.xov    = s_q.ctl3[pcx_pkg::CTL3_XOV_BIT];
    s_d.mirror = s_q.ctl3[pcx_pkg::CTL3_POL_BIT] && s_q.ctl3[pcx_pkg::CTL3_XOV_BIT];

    // Any enabled trigger drops the link; energy loss needs no count and drops it on the next cycle.
    s_d.drop = hit_rx || hit_mlt || hit_snr ||
               (s_q.ctl3[pcx_pkg::FLD_NRG_BIT] && energy_loss);
  end

  // State register; all control state starts from the documented defaults.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q      <= '0;
      s_q.ctl3 <= pcx_pkg::CTL3_RST;
      s_q.fn   <= pcx_pkg::pcx_fn_t'(pcx_pkg::ACC_CTL_RST[pcx_pkg::FN_HI:pcx_pkg::FN_LO]);
      s_q.dev  <= pcx_pkg::ACC_CTL_RST[pcx_pkg::DEV_HI:pcx_pkg::DEV_LO];
      s_q.ptr  <= pcx_pkg::PTR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign mgmt_rdata     = s_q.rdata;
  assign mgmt_rvalid    = s_q.rvalid;
  assign ext_wr         = s_q.ext_wr;
  assign ext_rd         = s_q.ext_rd;
  assign ext_addr       = s_q.ext_addr;
  assign ext_wdata      = s_q.ext_wdata;
  assign polarity_swap  = s_q.pol;
  assign pair_crossover = s_q.xov;
  assign port_mirror    = s_q.mirror;
  assign link_drop      = s_q.drop;

  // A read is answered exactly two cycles after it is taken.
  sequence s_read_answer;
    ##2 mgmt_rvalid;
  endsequence

  property p_rsv_zero;
    @(posedge clk) disable iff (sys_rst)
      (mgmt_rd && !mgmt_wr && mgmt_addr == pcx_pkg::OFF_CTL3)
      |-> s_read_answer ##0 ((mgmt_rdata & ~pcx_pkg::CTL3_WMASK) == 16'h0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

  property p_pol;
    @(posedge clk) disable iff (sys_rst)
      (mgmt_wr && mgmt_addr == pcx_pkg::OFF_CTL3)
      |-> ##2 (polarity_swap == $past(mgmt_wdata[pcx_pkg::CTL3_POL_BIT], 2));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity output wrong");

  property p_xov;
    @(posedge clk) disable iff (sys_rst)
      (mgmt_wr && mgmt_addr == pcx_pkg::OFF_CTL3)
      |-> ##2 (pair_crossover == $past(mgmt_wdata[pcx_pkg::CTL3_XOV_BIT], 2));
  endproperty
  a_xov: assert property (p_xov) else $error("crossover output wrong");

  property p_mirror;
    @(posedge clk) disable iff (sys_rst)
      port_mirror |-> (polarity_swap && pair_crossover);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror without both swaps");

  property p_energy;
    @(posedge clk) disable iff (sys_rst)
      (s_q.ctl3[pcx_pkg::FLD_NRG_BIT] && energy_loss) |=> link_drop;
  endproperty
  a_energy: assert property (p_energy) else $error("energy loss not dropped");

  property p_drop_cause;
    @(posedge clk) disable iff (sys_rst)
      link_drop |-> $past(hit_rx || hit_mlt || hit_snr ||
                          (s_q.ctl3[pcx_pkg::FLD_NRG_BIT] && energy_loss));
  endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop without cause");

  property p_ptr_load;
    @(posedge clk) disable iff (sys_rst)
      (wr_ad && dev_ok && s_q.fn == pcx_pkg::PCX_FN_ADDR) |=> (s_q.ptr == $past(mgmt_wdata));
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_ptr_keep;
    @(posedge clk) disable iff (sys_rst)
      ((wr_ad || rd_ad) && s_q.fn == pcx_pkg::PCX_FN_DATA) |=> $stable(s_q.ptr);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer moved");

  property p_ptr_inc;
    @(posedge clk) disable iff (sys_rst)
      ((wr_ad || rd_ad) && dev_ok && s_q.fn == pcx_pkg::PCX_FN_INC_RW)
      |=> (s_q.ptr == $past(s_q.ptr) + 16'h0001) && (ext_addr == $past(s_q.ptr));
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not stepped");

  property p_ptr_wr_only;
    @(posedge clk) disable iff (sys_rst)
      (rd_ad && dev_ok && s_q.fn == pcx_pkg::PCX_FN_INC_WR) |=> $stable(s_q.ptr) && ext_rd;
  endproperty
  a_ptr_wr_only: assert property (p_ptr_wr_only) else $error("read stepped pointer");

  property p_foreign_dev;
    @(posedge clk) disable iff (sys_rst)
      ((wr_ad || rd_ad) && !dev_ok) |=> (!ext_wr && !ext_rd && $stable(s_q.ptr));
  endproperty
  a_foreign_dev: assert property (p_foreign_dev) else $error("foreign id acted on");

  property p_ext_only_ptr;
    @(posedge clk) disable iff (sys_rst)
      (ext_wr || ext_rd) |-> $past(mgmt_addr == pcx_pkg::OFF_ADDAT);
  endproperty
  a_ext_only_ptr: assert property (p_ext_only_ptr) else $error("direct extended access");

  // A fired count trigger must reach the link pin on the very next cycle.
  property p_count_drop;
    @(posedge clk) disable iff (sys_rst)
      (hit_rx || hit_mlt || hit_snr) |=> link_drop;
  endproperty
  a_count_drop: assert property (p_count_drop) else $error("count trigger not dropped");

  // The shared window restarts right after its last cycle, so no window runs long.
  property p_win_wrap;
    @(posedge clk) disable iff (sys_rst)
      (s_q.win == pcx_pkg::WIN_LAST) |=> win_start;
  endproperty
  a_win_wrap: assert property (p_win_wrap) else $error("window did not restart");

endmodule

//--- tb/pcx_ext_model.sv
// Far-side model: the extended register store reached through the pointer.
// Assumes the extended strobes of pcx_ctrl3_indirect on the same clock.
`timescale 1ns/100ps

module pcx_ext_model (
  input  wire logic        clk,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  output logic [15:0]      ext_rdata
);
  logic [15:0] mem [logic [15:0]];  // Sparse store; unwritten words read as the inverted address.
  logic [15:0] junk_q = 16'h5a5a;   // Changes every cycle so stale data never looks like an answer.

  // Writes land on the edge that samples the strobe.
  always @(posedge clk)
  begin
    junk_q <= ~junk_q ^ 16'h0101;
    if (ext_wr)
    begin
      mem[ext_addr] = ext_wdata;
    end
  end

  // Read data is valid only while the read strobe is high, as the block expects.
  always @*
  begin
    if (ext_rd)
      ext_rdata = mem.exists(ext_addr) ? mem[ext_addr] : ~ext_addr;
    else
      ext_rdata = junk_q;
  end
endmodule

//--- tb/phy_ctrl3_and_indirect_ext_access_tb.sv
// Self-checking bench for the control-3 and indirect access block.
// Assumes pcx_pkg and the design are compiled first, and pcx_ext_model beside it.
`timescale 1ns/100ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

module phy_ctrl3_and_indirect_ext_access_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  mgmt_addr = 5'h00;
  logic        mgmt_wr = 1'b0;
  logic        mgmt_rd = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid;
  logic        ext_wr;
  logic        ext_rd;
  logic [15:0] ext_addr;
  logic [15:0] ext_wdata;
  logic [15:0] ext_rdata;
  logic [2:0]  evts = 3'h0;          // Receive error, coding violation, low SNR.
  logic        energy_loss = 1'b0;
  logic        polarity_swap;
  logic        pair_crossover;
  logic        port_mirror;
  logic        link_drop;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic        drop_seen = 1'b0;     // Set by the monitor when the link is dropped.
  // Reference model of the registers and the extended store.
  logic [15:0] m_ctl = 16'h0000;
  logic [15:0] m_ptr = 16'h0000;
  logic [1:0]  m_fn = 2'h0;
  logic [4:0]  m_dev = 5'h00;
  logic [15:0] m_mem [logic [15:0]];
  logic [15:0] base;

  // 40 MHz clock.
  always #12.5 clk = ~clk;

  pcx_ctrl3_indirect dut (
    .clk(clk), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .ext_wr(ext_wr),
    .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .rx_err_evt(evts[0]), .mlt3_viol_evt(evts[1]), .low_snr_evt(evts[2]), .energy_loss(energy_loss),
    .polarity_swap(polarity_swap), .pair_crossover(pair_crossover), .port_mirror(port_mirror),
    .link_drop(link_drop));

  pcx_ext_model u_ext (
    .clk(clk), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  // Sample the registered drop output away from the launching edge.
  always @(negedge clk)
  begin
    if (link_drop === 1'b1)
      drop_seen = 1'b1;
  end

  // Cut a hang short; the whole run needs about 4300 cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      results();
    end
  end

  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One register write, mirrored into the model.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    mgmt_wr    <= 1'b1;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    if (a == pcx_pkg::OFF_CTL3)
      m_ctl = d & 16'h007f;
    else if (a == pcx_pkg::OFF_ACC_CTL)
    begin
      m_fn  = d[15:14];
      m_dev = d[4:0];
    end
    else if (a == pcx_pkg::OFF_ADDAT && m_dev == 5'h1f)
    begin
      if (m_fn == 2'h0)
        m_ptr = d;
      else
      begin
        m_mem[m_ptr] = d;
        if (m_fn != 2'h1)
          m_ptr++;
      end
    end
  endtask

  // One register read; the answer is compared with the model's value.
  task automatic rd(input logic [4:0] a);
    logic [15:0] e;
    e = 16'h0000;                    // Unmapped places and refused accesses read zero.
    if (a == pcx_pkg::OFF_CTL3)
      e = m_ctl;
    else if (a == pcx_pkg::OFF_ACC_CTL)
      e = {m_fn, 9'h000, m_dev};
    else if (a == pcx_pkg::OFF_ADDAT && m_dev == 5'h1f)
    begin
      if (m_fn == 2'h0)
        e = m_ptr;
      else
      begin
        e = m_mem.exists(m_ptr) ? m_mem[m_ptr] : ~m_ptr;
        if (m_fn == 2'h2)
          m_ptr++;
      end
    end
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_rd   <= 1'b1;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1;
      if (mgmt_rvalid === 1'b1)
        break;
    end
    `CHK(mgmt_rvalid, 1'b1)
    `CHK(mgmt_rdata, e)
  endtask

  // Drive one event line with a pulse every per cycles; per 1 holds it high.
  task automatic pulse(input int line, input int per, input int cnt);
    for (int j = 0; j < per * cnt; j++)
    begin
      @(posedge clk);
      evts[line] <= (j % per == 0);
    end
    @(posedge clk);
    evts <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    void'($urandom(32'hbaf0));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(pcx_pkg::OFF_CTL3);
    rd(pcx_pkg::OFF_ACC_CTL);
    rd(pcx_pkg::OFF_ADDAT);
    wr(5'h11, 16'hffff);
    rd(5'h11);
    // Every combination of the two swap bits, random reserved bits, triggers off.
    for (int i = 0; i < 4; i++)
    begin
      wr(pcx_pkg::OFF_CTL3, (16'($urandom) & 16'hff90) | 16'(i << 5));
      rd(pcx_pkg::OFF_CTL3);
      `CHK(polarity_swap, i[1])
      `CHK(pair_crossover, i[0])
      `CHK(port_mirror, i == 3)
    end
    // A foreign target id must leave the pointer alone.
    wr(pcx_pkg::OFF_ACC_CTL, 16'h001e);
    wr(pcx_pkg::OFF_ADDAT, 16'h0040);
    rd(pcx_pkg::OFF_ADDAT);
    wr(pcx_pkg::OFF_ACC_CTL, 16'hffff);
    rd(pcx_pkg::OFF_ACC_CTL);
    wr(pcx_pkg::OFF_ACC_CTL, 16'h001f);
    base = 16'($urandom);
    wr(pcx_pkg::OFF_ADDAT, base);
    rd(pcx_pkg::OFF_ADDAT);
    // Each data mode: writes and reads, then the pointer is read back in address mode.
    for (int f = 1; f < 4; f++)
    begin
      wr(pcx_pkg::OFF_ACC_CTL, {2'(f), 14'h001f});
      repeat (2)
      begin
        wr(pcx_pkg::OFF_ADDAT, 16'($urandom));
        rd(pcx_pkg::OFF_ADDAT);
      end
      wr(pcx_pkg::OFF_ACC_CTL, 16'h001f);
      rd(pcx_pkg::OFF_ADDAT);
    end
    // Read back what the far side stored, stepping the pointer on reads.
    wr(pcx_pkg::OFF_ADDAT, base);
    wr(pcx_pkg::OFF_ACC_CTL, 16'h801f);
    repeat (6) rd(pcx_pkg::OFF_ADDAT);
    // No trigger enabled: dense events on all lines must not drop the link.
    wr(pcx_pkg::OFF_CTL3, 16'h0000);
    drop_seen = 1'b0;
    for (int t = 0; t < 3; t++)
      pulse(t, 1, 80);
    `CHK(drop_seen, 1'b0)
    // Sparse events stay below the threshold in any window; dense ones pass it.
    for (int t = 0; t < 3; t++)
    begin
      wr(pcx_pkg::OFF_CTL3, 16'h0008 >> t);
      drop_seen = 1'b0;
      pulse(t, (t == 0) ? 13 : 22, (t == 0) ? 93 : 55);
      `CHK(drop_seen, 1'b0)
      pulse(t, 1, 80);
      `CHK(drop_seen, 1'b1)
    end
    // Energy loss is ignored unless bit 0 is set, then it holds the drop.
    wr(pcx_pkg::OFF_CTL3, 16'h000e);
    drop_seen = 1'b0;
    energy_loss <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(drop_seen, 1'b0)
    wr(pcx_pkg::OFF_CTL3, 16'h000f);
    repeat (4) @(posedge clk);
    #1;
    `CHK(link_drop, 1'b1)
    // Inputs change only on a rising edge, never just after one.
    @(posedge clk);
    energy_loss <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(link_drop, 1'b0)
    results();
  end
endmodule
